// >>> logic/prg_defines.svh
`ifndef PRG_DEFINES_SVH
`define PRG_DEFINES_SVH
// ==========================================================
// Register offsets
`define PRG_OFS_TAKEOVER 8'h44
`define PRG_OFS_DRIVE    8'h45
`define PRG_OFS_LEVEL    8'h46
`define PRG_OFS_OBSERVE  8'h47
`define PRG_OFS_REVISION 8'h7F
// ==========================================================
// Field positions
`define PRG_BIT_SIGNAL_IN 7
`define PRG_BIT_CLOCK_OUT 6
`define PRG_BIT_SEL_HI   5
`define PRG_BIT_SEL_LO   4
`define PRG_SCAN_MSB     3
`define PRG_SCAN_LSB     0
`define PRG_BIT_FAST     7
`define PRG_SEL_MSB      3
`define PRG_SEL_LSB      0
// ==========================================================
// Reset values
`define PRG_RST_TAKEOVER 8'h00
`define PRG_RST_DRIVE    8'h00
`define PRG_RST_FAST     1'b0
`define PRG_RST_SEL      4'h0
`endif

// >>> logic/prg_pkg.sv
package prg_pkg;
	// Observe source select codes
	typedef enum logic [3:0] {
		PRG_OBS_HIZ0   = 4'h0,
		PRG_OBS_HIZ1   = 4'h1,
		PRG_OBS_LOW    = 4'h2,
		PRG_OBS_HIGH   = 4'h3,
		PRG_OBS_TX_ENV = 4'h4,
		PRG_OBS_TX_ACT = 4'h5,
		PRG_OBS_SECURE = 4'h6,
		PRG_OBS_RX_ENV = 4'h7,
		PRG_OBS_RX_ACT = 4'h8,
		PRG_OBS_RX_BIT = 4'h9
	} prg_obs_e;
	typedef logic [7:0] prg_byte_t;
endpackage : prg_pkg

// >>> logic/prg_pin_reuse.sv
`timescale 1ns/100ps
`include "prg_defines.svh"
// Overview of operation
// [R1] Takeover bit 7 hands the signal-input pin to register-driven I/O.
// [R2] Takeover bit 6 stops the clock output function; pin becomes I/O.
// [R3] Takeover bits 5 and 4 make the host select pins register-driven I/O.
// [R4] Takeover bits 3..0 make TCK, TMS, TDI, TDO register-driven I/O.
// [R5] With boundary scan enabled, scan takeover bits are ignored.
// [R6] Drive-value register at 45h holds one output bit per pin.
// [R7] Read-only level register at 46h samples all eight pin inputs.
// [R8] Observe register bit 7 selects fast pads; bits 6..4 reserved.
// [R9] Observe codes 0,1 high impedance; 2 drives low; 3 drives high.
// [R10] Codes 4,5,6 show transmit envelope, transmit active, secure link.
// [R11] Codes 7,8,9 show receive envelope, receive active, received bits.
// [R12] Revision register 7Fh reports major version in bits 7..4.
// [R13] Revision bits 3..0 report subversion code.
// [R14] With takeover clear, pin driver stays with its dedicated function.
// [R15] Observe codes above 9 are reserved and give high impedance.
module prg_pin_reuse #(
	parameter logic [3:0] MAJOR_VERSION = 4'h3, // Arbitrary value
	parameter logic [3:0] SUB_VERSION   = 4'h5  // Arbitrary value
) (
	// Clock and synchronous reset
	input  wire logic               REF_CLK_I,
	input  wire logic               RST_I,
	// Register bus; read data one cycle after the strobe
	input  wire logic [7:0]         ADDR_I,
	input  wire prg_pkg::prg_byte_t WDATA_I,
	input  wire logic               WR_I,
	input  wire logic               RD_I,
	output logic      [7:0]         RDATA_O,
	// Dedicated functions and pads, bit 7 down to bit 0
	input  wire logic               SCAN_ACTIVE_I,
	input  wire logic [7:0]         FUNC_OUT_I,
	input  wire logic [7:0]         FUNC_OE_N_I,
	input  wire logic [7:0]         PIN_IN_I,
	output logic      [7:0]         PIN_OUT_O,
	output logic      [7:0]         PIN_OE_N_O,
	// Internal signals that may be shown on the observation pin
	input  wire logic               TX_ENVELOPE_I,
	input  wire logic               TX_ACTIVE_I,
	input  wire logic               GENERIC_SECURE_LINK_SIGNAL_I,
	input  wire logic               RX_ENVELOPE_I,
	input  wire logic               RX_ACTIVE_I,
	input  wire logic               RX_BIT_I,
	// Observation pin and pad speed
	output logic                    OBSERVE_PIN_O,
	output logic                    OBSERVE_PIN_OE_N_O,
	output logic                    FAST_EDGE_SELECT_O
);
	import prg_pkg::*;

	// ==========================================================
	// Register file
	// Bit order shared by the takeover, drive and level registers:
	//   7 signal-input pin, 6 clock output pin,
	//   5 host select high, 4 host select low,
	//   3 TCK, 2 TMS, 1 TDI, 0 TDO.
	// The slave never stalls the master: writes land at the strobe edge.
	logic [7:0] pin_takeover_enable;
	logic [7:0] pin_drive_value;
	logic       fast_edge_select;
	logic [3:0] observe_source_select;
	logic [7:0] rdata;
	logic [7:0] next_pin_takeover_enable;
	logic [7:0] next_pin_drive_value;
	logic       next_fast_edge_select;
	logic [3:0] next_observe_source_select;
	logic [7:0] next_rdata;
	logic       wr_takeover;
	logic       wr_drive;
	logic       wr_observe;
	logic       rd_takeover;
	logic       rd_drive;
	logic       rd_level;
	logic       rd_observe;
	logic       rd_revision;

	// Shared address match
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Strobe-qualified decodes; level and revision offsets have no write decode,
	// so writes there are dropped without touching any stored state
	assign wr_takeover = WR_I & hit(ADDR_I, `PRG_OFS_TAKEOVER);
	assign wr_drive    = WR_I & hit(ADDR_I, `PRG_OFS_DRIVE);
	assign wr_observe  = WR_I & hit(ADDR_I, `PRG_OFS_OBSERVE);
	assign rd_takeover = RD_I & hit(ADDR_I, `PRG_OFS_TAKEOVER);
	assign rd_drive    = RD_I & hit(ADDR_I, `PRG_OFS_DRIVE);
	assign rd_level    = RD_I & hit(ADDR_I, `PRG_OFS_LEVEL);
	assign rd_observe  = RD_I & hit(ADDR_I, `PRG_OFS_OBSERVE);
	assign rd_revision = RD_I & hit(ADDR_I, `PRG_OFS_REVISION);

	// ==========================================================
	// Takeover enable register
	// Scan bits are stored even while scan runs; the mask sits at the pins,
	// so software reads back exactly what it wrote
	always_comb begin
		next_pin_takeover_enable = pin_takeover_enable;
		if (wr_takeover) begin
			next_pin_takeover_enable = WDATA_I; // [R1] [R2] [R3] [R4]
		end
	end

	// Reset returns every pin to its dedicated function
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			pin_takeover_enable <= `PRG_RST_TAKEOVER;
		end else begin
			pin_takeover_enable <= next_pin_takeover_enable;
		end
	end

	// ==========================================================
	// Drive value register
	// Bits of pins still under their dedicated function are kept, not shown
	always_comb begin
		next_pin_drive_value = pin_drive_value;
		if (wr_drive) begin
			next_pin_drive_value = WDATA_I; // [R6]
		end
	end

	// Write the level before taking a pin over, or the pad shows a glitch
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			pin_drive_value <= `PRG_RST_DRIVE;
		end else begin
			pin_drive_value <= next_pin_drive_value;
		end
	end

	// ==========================================================
	// Observe control register
	// Bits 6..4 are reserved and not stored, so they always read as zero
	always_comb begin
		next_fast_edge_select      = fast_edge_select;
		next_observe_source_select = observe_source_select;
		if (wr_observe) begin
			next_fast_edge_select      = WDATA_I[`PRG_BIT_FAST]; // [R8]
			next_observe_source_select = WDATA_I[`PRG_SEL_MSB:`PRG_SEL_LSB]; // [R9] [R10] [R11]
		end
	end

	// Fast edges raise peak supply current; reset keeps the slow pads
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			fast_edge_select      <= `PRG_RST_FAST;
			observe_source_select <= `PRG_RST_SEL;
		end else begin
			fast_edge_select      <= next_fast_edge_select;
			observe_source_select <= next_observe_source_select;
		end
	end

	// ==========================================================
	// Read data
	// Unmapped reads return zero. Read data stand for one cycle only, so an
	// idle bus always sees zero and a stale value cannot be taken twice.
	// The level register samples the pads as they are, whoever drives them.
	always_comb begin
		next_rdata = 8'h00;
		if (rd_takeover) begin
			next_rdata = pin_takeover_enable; // [R1] [R2] [R3] [R4]
		end
		if (rd_drive) begin
			next_rdata = pin_drive_value; // [R6]
		end
		if (rd_level) begin
			next_rdata = PIN_IN_I; // [R7]
		end
		if (rd_observe) begin
			next_rdata = {fast_edge_select, 3'h0, observe_source_select}; // [R8]
		end
		if (rd_revision) begin
			next_rdata = {MAJOR_VERSION, SUB_VERSION}; // [R12] [R13]
		end
	end

	// Registered so the read port comes straight from a flop
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Pin ownership
	logic [7:0] pin_out;
	logic [7:0] pin_oe_n;
	logic [7:0] next_pin_out;
	logic [7:0] next_pin_oe_n;
	logic [7:0] effective_takeover;

	// Named views of the takeover bits, one per pin group
	logic       signal_in_pin_takeover;
	logic       clock_pin_takeover;
	logic       host_select_hi_takeover;
	logic       host_select_lo_takeover;
	logic [3:0] scan_pin_takeover;

	assign signal_in_pin_takeover  = pin_takeover_enable[`PRG_BIT_SIGNAL_IN]; // [R1]
	assign clock_pin_takeover      = pin_takeover_enable[`PRG_BIT_CLOCK_OUT]; // [R2]
	assign host_select_hi_takeover = pin_takeover_enable[`PRG_BIT_SEL_HI]; // [R3]
	assign host_select_lo_takeover = pin_takeover_enable[`PRG_BIT_SEL_LO]; // [R3]
	assign scan_pin_takeover       = pin_takeover_enable[`PRG_SCAN_MSB:`PRG_SCAN_LSB]; // [R4]

	// Scan mode wins over the scan pin takeover bits. The scan pins stay with
	// the scan interface for as long as scan is active, whatever software wrote;
	// when scan drops, the stored bits take effect again one cycle later.
	// Taking the clock output pin over stops the clock on that pad entirely.
	always_comb begin
		effective_takeover                     = 8'h00;
		effective_takeover[`PRG_BIT_SIGNAL_IN] = signal_in_pin_takeover; // [R1]
		effective_takeover[`PRG_BIT_CLOCK_OUT] = clock_pin_takeover; // [R2]
		effective_takeover[`PRG_BIT_SEL_HI]    = host_select_hi_takeover; // [R3]
		effective_takeover[`PRG_BIT_SEL_LO]    = host_select_lo_takeover; // [R3]
		if (SCAN_ACTIVE_I) begin
			effective_takeover[`PRG_SCAN_MSB:`PRG_SCAN_LSB] = 4'h0; // [R5]
		end else begin
			effective_takeover[`PRG_SCAN_MSB:`PRG_SCAN_LSB] = scan_pin_takeover; // [R4]
		end
	end

	// Per-pin mux between dedicated function and software drive
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			always_comb begin
				if (effective_takeover[g]) begin
					next_pin_out[g]  = pin_drive_value[g]; // [R1] [R2] [R3] [R4]
					next_pin_oe_n[g] = 1'b0;
				end else begin
					next_pin_out[g]  = FUNC_OUT_I[g]; // [R14]
					next_pin_oe_n[g] = FUNC_OE_N_I[g]; // [R14]
				end
			end
		end
	endgenerate

	// Pads come up released; the dedicated functions claim them after reset.
	// One cycle of latency from register or function input to the pad,
	// traded for outputs that never glitch on a decode change.
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			pin_out  <= 8'h00;
			pin_oe_n <= 8'hFF;
		end else begin
			pin_out  <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
		end
	end

	// ==========================================================
	// Observation pin
	logic obs_out;
	logic obs_oe_n;
	logic next_obs_out;
	logic next_obs_oe_n;

	// Source select; unknown codes float the pin.
	// Codes 0 and 1 release the pin; 2 and 3 drive fixed levels.
	// Codes 4 and 5 show the transmit side, 6 the secure link, 7 to 9 the receive side.
	// Codes above 9 are reserved and release the pin, so a stray
	// write can never drive an undefined signal onto the board.
	// The receive envelope means something for one 106 kBd protocol only;
	// other protocols show a level with no meaning there.
	// Sources are taken as synchronous; the flop below adds one cycle,
	// so pulses of one clock still reach the pin, one cycle late.
	always_comb begin
		next_obs_out  = 1'b0;
		next_obs_oe_n = 1'b0;
		unique case (observe_source_select)
			PRG_OBS_HIZ0, PRG_OBS_HIZ1: next_obs_oe_n = 1'b1; // [R9]
			PRG_OBS_LOW:    next_obs_out = 1'b0; // [R9]
			PRG_OBS_HIGH:   next_obs_out = 1'b1; // [R9]
			PRG_OBS_TX_ENV: next_obs_out = TX_ENVELOPE_I; // [R10]
			PRG_OBS_TX_ACT: next_obs_out = TX_ACTIVE_I; // [R10]
			PRG_OBS_SECURE: next_obs_out = GENERIC_SECURE_LINK_SIGNAL_I; // [R10]
			PRG_OBS_RX_ENV: next_obs_out = RX_ENVELOPE_I; // [R11]
			PRG_OBS_RX_ACT: next_obs_out = RX_ACTIVE_I; // [R11]
			PRG_OBS_RX_BIT: next_obs_out = RX_BIT_I; // [R11]
			default:        next_obs_oe_n = 1'b1; // [R15]
		endcase
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			obs_out  <= 1'b0;
			obs_oe_n <= 1'b1;
		end else begin
			obs_out  <= next_obs_out;
			obs_oe_n <= next_obs_oe_n;
		end
	end

	// ==========================================================
	// Outputs
	// All outputs straight from flops, so board timing sees no logic after
	// the register and reset values appear at the pins on the first clock edge of reset
	assign RDATA_O            = rdata;
	assign PIN_OUT_O          = pin_out;
	assign PIN_OE_N_O         = pin_oe_n;
	assign OBSERVE_PIN_O      = obs_out;
	assign OBSERVE_PIN_OE_N_O = obs_oe_n;
	assign FAST_EDGE_SELECT_O = fast_edge_select; // [R8]
endmodule : prg_pin_reuse

// >>> dv/prg_pin_reuse_monitor.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker: shadows register writes, ties outputs to them
module prg_pin_reuse_monitor #(
	parameter logic [3:0] MAJOR_VERSION = 4'h3,
	parameter logic [3:0] SUB_VERSION   = 4'h5
) (
	input wire logic               REF_CLK_I, RST_I, WR_I, RD_I, SCAN_ACTIVE_I,
	input wire logic [7:0]         ADDR_I, RDATA_O, FUNC_OUT_I, PIN_IN_I, PIN_OUT_O,
	input wire prg_pkg::prg_byte_t WDATA_I,
	input wire logic               TX_ENVELOPE_I, TX_ACTIVE_I, GENERIC_SECURE_LINK_SIGNAL_I,
	input wire logic               RX_ENVELOPE_I, RX_ACTIVE_I, RX_BIT_I,
	input wire logic               OBSERVE_PIN_O, OBSERVE_PIN_OE_N_O, FAST_EDGE_SELECT_O
);
	import prg_pkg::*;
	logic [7:0] tko, drv, eff, exp_pin;
	logic [4:0] obs;
	logic [1:0] quiet;
	logic [5:0] srcs;
	logic       obs_z, obs_v;
	// Shadows; quiet counts edges since last write so latency need not be exact
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			{tko, drv, obs, quiet} <= '0;
		end else begin
			quiet <= WR_I ? 2'h0 : quiet + {1'b0, ~&quiet};
			if (WR_I && ADDR_I == 8'h44) tko <= WDATA_I;
			if (WR_I && ADDR_I == 8'h45) drv <= WDATA_I;
			if (WR_I && ADDR_I == 8'h47) obs <= {WDATA_I[7], WDATA_I[3:0]};
		end
	end
	// Expected levels; scan keeps the low four pins
	assign eff     = tko & ~{4'h0, {4{SCAN_ACTIVE_I}}};
	assign exp_pin = (drv & eff) | (FUNC_OUT_I & ~eff);
	assign srcs    = {RX_BIT_I, RX_ACTIVE_I, RX_ENVELOPE_I, GENERIC_SECURE_LINK_SIGNAL_I, TX_ACTIVE_I, TX_ENVELOPE_I};
	assign obs_z   = obs[3:0] < 4'h2 || obs[3:0] > 4'h9;
	assign obs_v   = obs[3:0] == 4'h3 || (obs[3:0] != 4'h2 && srcs[obs[3:0] - 4'h4]);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	a_rdata_idle: assert property (!RD_I |=> RDATA_O == 8'h00)
		else $error("read data not cleared");
	a_drive_read: assert property (RD_I && ADDR_I == 8'h45 |=> RDATA_O == $past(drv))
		else $error("drive value readback wrong");
	a_level_read: assert property (RD_I && ADDR_I == 8'h46 |=> RDATA_O == $past(PIN_IN_I))
		else $error("pin level read wrong");
	a_revision_read: assert property (RD_I && ADDR_I == 8'h7F |=> RDATA_O == {MAJOR_VERSION, SUB_VERSION})
		else $error("revision read wrong");
	a_observe_read: assert property (RD_I && ADDR_I == 8'h47 |=> RDATA_O == {$past(obs[4]), 3'h0, $past(obs[3:0])})
		else $error("observe control read wrong");
	a_fast_edge: assert property (quiet[1] |-> FAST_EDGE_SELECT_O == obs[4])
		else $error("fast edge output wrong");
	a_pin_drive: assert property (quiet[1] |-> PIN_OUT_O == $past(exp_pin))
		else $error("pad output value wrong");
	a_observe_tristate: assert property (quiet[1] |-> OBSERVE_PIN_OE_N_O == $past(obs_z))
		else $error("observe enable wrong");
	a_observe_level: assert property (quiet[1] && !$past(obs_z) |-> OBSERVE_PIN_O == $past(obs_v))
		else $error("observe level wrong");
endmodule : prg_pin_reuse_monitor

// >>> dv/test_prg_pin_reuse.sv
`timescale 1ns/100ps
// ==========================================================
// Register-level bench for the pin reuse block
module test_prg_pin_reuse;
	import prg_pkg::*;
	logic       REF_CLK_I, RST_I, WR_I, RD_I, SCAN_ACTIVE_I, TX_ENVELOPE_I, TX_ACTIVE_I, exp_z;
	logic       GENERIC_SECURE_LINK_SIGNAL_I, RX_ENVELOPE_I, RX_ACTIVE_I, RX_BIT_I;
	logic       OBSERVE_PIN_O, OBSERVE_PIN_OE_N_O, FAST_EDGE_SELECT_O;
	logic [7:0] ADDR_I, RDATA_O, FUNC_OUT_I, FUNC_OE_N_I, PIN_IN_I, PIN_OUT_O, PIN_OE_N_O;
	prg_byte_t  WDATA_I;
	logic [5:0] src;
	int         err_count, n_tests;
	assign {RX_BIT_I, RX_ACTIVE_I, RX_ENVELOPE_I, GENERIC_SECURE_LINK_SIGNAL_I, TX_ACTIVE_I, TX_ENVELOPE_I} = src;
	prg_pin_reuse #(.MAJOR_VERSION(4'h6), .SUB_VERSION(4'h9)) u_dut (.*);
	// Compare, count and report
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge REF_CLK_I);
		{ADDR_I, WDATA_I, WR_I} <= {a, d, 1'b1};
		@(posedge REF_CLK_I);
		WR_I <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge REF_CLK_I);
		{ADDR_I, RD_I} <= {a, 1'b1};
		@(posedge REF_CLK_I);
		RD_I <= 1'b0;
		#1 chk(RDATA_O, exp);
	endtask : rdc
	// Pads follow registers with one cycle latency; three gives margin
	task automatic settle;
		repeat (3) @(posedge REF_CLK_I);
		#1;
	endtask : settle
	task automatic end_sim;
		$display("Checks: %0d errors: %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	initial begin
		REF_CLK_I = 1'b0;
		forever #5 REF_CLK_I = ~REF_CLK_I;
	end
	initial begin
		{RST_I, WR_I, RD_I, SCAN_ACTIVE_I, ADDR_I, WDATA_I} = {4'h8, 16'h0000};
		{FUNC_OUT_I, FUNC_OE_N_I, PIN_IN_I, src} = {24'hC3963C, 6'h2D};
		repeat (3) @(posedge REF_CLK_I);
		RST_I <= 1'b0;
		// Reset state, read-only places, unmapped address
		rdc(8'h44, 8'h00);
		wr(8'h46, 8'hFF);
		wr(8'h7F, 8'h00);
		rdc(8'h46, 8'h3C);
		rdc(8'h7F, 8'h69);
		rdc(8'h10, 8'h00);
		chk(PIN_OE_N_O, 8'h96);
		// Takeover of all pins, then scan reclaims the low four
		wr(8'h45, 8'h5A);
		wr(8'h44, 8'hFF);
		rdc(8'h45, 8'h5A);
		settle;
		chk(PIN_OUT_O, 8'h5A);
		chk(PIN_OE_N_O, 8'h00);
		SCAN_ACTIVE_I <= 1'b1;
		settle;
		chk(PIN_OUT_O, 8'h53);
		chk(PIN_OE_N_O, 8'h06);
		wr(8'h44, 8'h0F);
		settle;
		chk(PIN_OUT_O, 8'hC3);
		chk(PIN_OE_N_O, 8'h96);
		SCAN_ACTIVE_I <= 1'b0;
		settle;
		chk(PIN_OUT_O, 8'hCA);
		// Every select code with both source patterns
		for (int p = 0; p < 2; p++) begin
			src <= p ? 6'h12 : 6'h2D;
			for (int i = 0; i < 16; i++) begin
				wr(8'h47, {i[0], 3'h7, i[3:0]});
				rdc(8'h47, {i[0], 3'h0, i[3:0]});
				settle;
				exp_z = i < 2 || i > 9;
				chk({7'h00, OBSERVE_PIN_OE_N_O}, {7'h00, exp_z});
				if (!exp_z) chk({7'h00, OBSERVE_PIN_O}, {7'h00, i == 3 || (i != 2 && src[i - 4])});
				chk({7'h00, FAST_EDGE_SELECT_O}, {7'h00, i[0]});
			end
		end
		end_sim;
	end
endmodule : test_prg_pin_reuse
bind prg_pin_reuse prg_pin_reuse_monitor #(.MAJOR_VERSION(MAJOR_VERSION), .SUB_VERSION(SUB_VERSION)) u_mon (.*);
